// File: include/seg_desc_pkg.sv
/*
  Shared constants, field positions and carriers for the segment
  descriptor decoder and its descriptor cache.
  Assumes a single core clock domain; no timescale in this file.
*/
package seg_desc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int SEG_COUNT       = 6;
  localparam int CACHE_DEPTH     = 8;
  localparam int CACHE_AW        = 3;
  localparam int DESC_W          = 64;
  localparam int DESC_BYTES      = 8;
  localparam int WORD_STEP       = 4;

  // ----------------------------------------------------------------
  // Selector fields
  // ----------------------------------------------------------------
  localparam int SEL_PRIV_LSB    = 0;
  localparam int SEL_TABLE_BIT   = 2;
  localparam int SEL_IDX_LSB     = 3;
  localparam int SEL_IDX_W       = 13;

  // ----------------------------------------------------------------
  // Descriptor fields (bit positions in the 64-bit descriptor)
  // ----------------------------------------------------------------
  localparam int D_LIMLO_LSB     = 0;
  localparam int D_BASELO_LSB    = 16;
  localparam int D_TYPE_LSB      = 40;
  localparam int D_S_BIT         = 44;
  localparam int D_PRIV_LSB      = 45;
  localparam int D_P_BIT         = 47;
  localparam int D_LIMHI_LSB     = 48;
  localparam int D_B_BIT         = 54;
  localparam int D_G_BIT         = 55;
  localparam int D_BASEHI_LSB    = 56;
  localparam int D_UPPER_LSB     = 48;
  localparam int G_SEL_LSB       = 16;
  localparam int G_WC_LSB        = 32;
  localparam int G_OFFHI_LSB     = 48;

  // ----------------------------------------------------------------
  // Type codes and fault vectors
  // ----------------------------------------------------------------
  localparam logic [3:0] T_TASK_GATE = 4'h5;
  localparam logic [3:0] T_TASK_SEG_A16 = 4'h1;
  localparam logic [3:0] T_TASK_SEG_B16 = 4'h3;
  localparam logic [3:0] T_TASK_SEG_A32 = 4'h9;
  localparam logic [3:0] T_TASK_SEG_B32 = 4'hB;
  localparam int         T_NATIVE_BIT = 3;
  localparam int         T_CODE_BIT   = 3;
  localparam logic [7:0] VEC_NONE    = 8'h00;
  localparam logic [7:0] VEC_NOT_PRESENT = 8'h0B;
  localparam logic [7:0] VEC_GEN_PROT    = 8'h0D;
  localparam logic [6:0] ITEM_BYTES_16   = 7'h02;
  localparam logic [6:0] ITEM_BYTES_32   = 7'h04;

  typedef struct packed {
    logic [31:0] base;
    logic [19:0] limit;
    logic        gran;
    logic        big;
    logic        present;
    logic [1:0]  descriptor_privilege;
    logic        code_data;
    logic [3:0]  seg_type;
    logic        legacy;
  } seg_info_s;

  typedef struct packed {
    logic [15:0] dest_selector;
    logic [31:0] dest_offset;
    logic [4:0]  word_count;
    logic [6:0]  param_bytes;
    logic        native;
    logic        task_gate;
    logic        push_wide;
    logic [7:0]  fault_vec;
  } gate_info_s;

  typedef struct packed {
    logic [1:0]            requested_privilege;
    logic                  table_select_bit;
    logic [SEL_IDX_W-1:0]  index;
  } sel_fields_s;

endpackage

// File: verilog/desc_cache_mem.sv
/*
  Descriptor cache storage: one 64-bit entry per segment register.
  Single write port, single read port with registered read data.
  Assumes one clock, synchronous active-low reset.
*/
`timescale 1ns/1ps
module desc_cache_mem
  import seg_desc_pkg::*;
(
  input  wire logic                         core_clk,
  input  wire logic                         rst_n,
  input  wire logic                         wr_en,
  input  wire logic [seg_desc_pkg::CACHE_AW-1:0] wr_addr,
  input  wire logic [seg_desc_pkg::DESC_W-1:0]   wr_data,
  input  wire logic                         rd_en,
  input  wire logic [seg_desc_pkg::CACHE_AW-1:0] rd_addr,
  output logic      [seg_desc_pkg::DESC_W-1:0]   rd_data
);

  logic [DESC_W-1:0] store_reg [CACHE_DEPTH];
  logic [DESC_W-1:0] rd_data_reg;

  always_ff @(posedge core_clk)
  begin
    if (wr_en)
      store_reg[wr_addr] <= wr_data;
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      rd_data_reg <= '0;
    else if (rd_en)
      rd_data_reg <= store_reg[rd_addr];
  end

  assign rd_data = rd_data_reg;

endmodule // desc_cache_mem

// File: verilog/segment_descriptor_decode_cache.sv
/*
  Segment descriptor decoder and per-segment descriptor cache.
  Loads a descriptor from the table in memory on a selector write,
  serves references from the cache, and decodes gate descriptors.
  Assumes a same-clock memory port that acks each 32-bit read once.
*/
`timescale 1ns/1ps
// Contract
// - Upper word zero means legacy descriptor
// - Native 32/20+G base/limit, legacy 24/16
// - Word count counts 16- or 32-bit items
// - Stack B bit picks push width
// - Gate selector names code segment or task
// - Gate offset 16 legacy, 32 native
// - Selector gives table, index, requested privilege
// - Selector write fetches 8-byte descriptor
// - References served from cache, no refetch
// - Cache changes only on segment reload
// - No software readback of cache contents
// - Absent gate raises fault 11
// - Wrong target type raises fault 13
module segment_descriptor_decode_cache
  import seg_desc_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic [31:0]          global_table_base,
  input  wire logic [31:0]          local_table_base,
  input  wire logic                 seg_wr_valid,
  input  wire logic [2:0]           seg_wr_idx,
  input  wire logic [15:0]          seg_wr_selector,
  output logic                      seg_wr_ready,
  output logic                      seg_load_done,
  output seg_desc_pkg::sel_fields_s seg_sel_fields,
  output logic                      mem_req,
  output logic      [31:0]          mem_addr,
  input  wire logic                 mem_ack,
  input  wire logic [31:0]          mem_rdata,
  input  wire logic                 ref_valid,
  input  wire logic [2:0]           ref_idx,
  output logic                      ref_done,
  output seg_desc_pkg::seg_info_s   ref_info,
  input  wire logic                 gate_valid,
  input  wire logic [63:0]          gate_desc,
  input  wire logic [63:0]          target_desc,
  input  wire logic                 stack_b_bit,
  output logic                      gate_done,
  output seg_desc_pkg::gate_info_s  gate_info
);

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------
  function automatic sel_fields_s split_selector(input logic [15:0] sel);
    sel_fields_s f;
    f.requested_privilege = sel[SEL_PRIV_LSB +: 2];
    f.table_select_bit    = sel[SEL_TABLE_BIT];
    f.index               = sel[SEL_IDX_LSB +: SEL_IDX_W];
    return f;
  endfunction

  function automatic seg_info_s decode_seg(input logic [63:0] d);
    seg_info_s s;
    s.legacy  = (d[D_UPPER_LSB +: 16] == 16'h0000);
    s.base    = {d[D_BASEHI_LSB +: 8], d[D_BASELO_LSB +: 24]};
    s.limit   = {d[D_LIMHI_LSB +: 4], d[D_LIMLO_LSB +: 16]};
    s.gran    = d[D_G_BIT];
    s.big     = d[D_B_BIT];
    s.present = d[D_P_BIT];
    s.descriptor_privilege = d[D_PRIV_LSB +: 2];
    s.code_data = d[D_S_BIT];
    s.seg_type  = d[D_TYPE_LSB +: 4];
    return s;
  endfunction

  function automatic logic is_task_seg(input seg_info_s s);
    return !s.code_data && (s.seg_type == T_TASK_SEG_A16 || s.seg_type == T_TASK_SEG_B16 ||
                            s.seg_type == T_TASK_SEG_A32 || s.seg_type == T_TASK_SEG_B32);
  endfunction

  // ----------------------------------------------------------------
  // Descriptor load state machine
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_FETCH_LO = 2'b01,
    ST_FETCH_HI = 2'b10
  } load_state_e;

  load_state_e state_reg, state_next;
  logic [2:0]  slot_reg, slot_next;
  logic [31:0] lo_reg, lo_next;
  logic [31:0] addr_reg, addr_next;
  logic        req_reg, req_next;
  logic        ready_reg, ready_next;
  logic        done_reg, done_next;
  sel_fields_s sel_reg, sel_next;
  sel_fields_s wr_fields;
  logic [31:0] tbl_base;
  logic        cache_we;
  logic [63:0] cache_wdata;

  assign wr_fields   = split_selector(seg_wr_selector);
  assign tbl_base    = wr_fields.table_select_bit ? local_table_base : global_table_base;
  // Only the load machine writes the cache; nothing else touches it
  assign cache_we    = (state_reg == ST_FETCH_HI) && mem_ack;
  assign cache_wdata = {mem_rdata, lo_reg};

  always_comb
  begin
    state_next = state_reg;
    slot_next  = slot_reg;
    lo_next    = lo_reg;
    addr_next  = addr_reg;
    req_next   = req_reg;
    ready_next = ready_reg;
    done_next  = 1'b0;
    sel_next   = sel_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (seg_wr_valid && ready_reg)
        begin
          slot_next  = seg_wr_idx;
          sel_next   = wr_fields;
          addr_next  = tbl_base + {16'h0000, wr_fields.index, 3'b000};
          req_next   = 1'b1;
          ready_next = 1'b0;
          state_next = ST_FETCH_LO;
        end
      end
      ST_FETCH_LO:
      begin
        if (mem_ack)
        begin
          lo_next    = mem_rdata;
          addr_next  = addr_reg + 32'(WORD_STEP);
          state_next = ST_FETCH_HI;
        end
      end
      ST_FETCH_HI:
      begin
        if (mem_ack)
        begin
          req_next   = 1'b0;
          ready_next = 1'b1;
          done_next  = 1'b1;
          state_next = ST_IDLE;
        end
      end
      default:
      begin
        req_next   = 1'b0;
        ready_next = 1'b1;
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      slot_reg  <= '0;
      lo_reg    <= '0;
      addr_reg  <= '0;
      req_reg   <= 1'b0;
      ready_reg <= 1'b1;
      done_reg  <= 1'b0;
      sel_reg   <= '0;
    end
    else
    begin
      state_reg <= state_next;
      slot_reg  <= slot_next;
      lo_reg    <= lo_next;
      addr_reg  <= addr_next;
      req_reg   <= req_next;
      ready_reg <= ready_next;
      done_reg  <= done_next;
      sel_reg   <= sel_next;
    end
  end

  assign seg_wr_ready   = ready_reg;
  assign seg_load_done  = done_reg;
  assign seg_sel_fields = sel_reg;
  assign mem_req        = req_reg;
  assign mem_addr       = addr_reg;

  // ----------------------------------------------------------------
  // Cache storage and reference path
  // ----------------------------------------------------------------
  // Read port feeds only the decoder, never a software-visible path
  logic [63:0] cache_rdata;

  desc_cache_mem u_cache (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .wr_en    (cache_we),
    .wr_addr  (slot_reg),
    .wr_data  (cache_wdata),
    .rd_en    (ref_valid),
    .rd_addr  (ref_idx),
    .rd_data  (cache_rdata)
  );

  // ----------------------------------------------------------------
  // Reference decode and gate decode
  // ----------------------------------------------------------------
  logic       pend_reg, pend_next;
  logic       rdone_reg, rdone_next;
  seg_info_s  rinfo_reg, rinfo_next;
  logic       gdone_reg, gdone_next;
  gate_info_s ginfo_reg, ginfo_next;
  seg_info_s  gate_seg;
  seg_info_s  tgt_seg;
  seg_info_s  cached;

  assign gate_seg = decode_seg(gate_desc);
  assign tgt_seg  = decode_seg(target_desc);
  assign cached   = decode_seg(cache_rdata);

  always_comb
  begin
    pend_next  = ref_valid;
    rdone_next = pend_reg;
    rinfo_next = rinfo_reg;
    if (pend_reg)
    begin
      rinfo_next = cached;
      if (cached.legacy)
      begin
        rinfo_next.base[31:24]  = 8'h00;
        rinfo_next.limit[19:16] = 4'h0;
        rinfo_next.gran         = 1'b0;
      end
    end
    gdone_next = gate_valid;
    ginfo_next = ginfo_reg;
    if (gate_valid)
    begin
      ginfo_next.native        = gate_seg.seg_type[T_NATIVE_BIT];
      ginfo_next.task_gate     = (gate_seg.seg_type == T_TASK_GATE);
      ginfo_next.dest_selector = gate_desc[G_SEL_LSB +: 16];
      ginfo_next.dest_offset   = {16'h0000, gate_desc[15:0]};
      if (gate_seg.seg_type[T_NATIVE_BIT])
        ginfo_next.dest_offset[31:16] = gate_desc[G_OFFHI_LSB +: 16];
      ginfo_next.word_count    = gate_desc[G_WC_LSB +: 5];
      ginfo_next.param_bytes   = 7'(gate_desc[G_WC_LSB +: 5]) *
        (gate_seg.seg_type[T_NATIVE_BIT] ? ITEM_BYTES_32 : ITEM_BYTES_16);
      ginfo_next.push_wide     = stack_b_bit;
      if (!gate_seg.present)
        ginfo_next.fault_vec = VEC_NOT_PRESENT;
      else if (ginfo_next.task_gate ? !is_task_seg(tgt_seg) :
               !(tgt_seg.code_data && tgt_seg.seg_type[T_CODE_BIT]))
        ginfo_next.fault_vec = VEC_GEN_PROT;
      else
        ginfo_next.fault_vec = VEC_NONE;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pend_reg  <= 1'b0;
      rdone_reg <= 1'b0;
      rinfo_reg <= '0;
      gdone_reg <= 1'b0;
      ginfo_reg <= '0;
    end
    else
    begin
      pend_reg  <= pend_next;
      rdone_reg <= rdone_next;
      rinfo_reg <= rinfo_next;
      gdone_reg <= gdone_next;
      ginfo_reg <= ginfo_next;
    end
  end

  assign ref_done  = rdone_reg;
  assign ref_info  = rinfo_reg;
  assign gate_done = gdone_reg;
  assign gate_info = ginfo_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_legacy_detect: assert property (
    pend_reg |=> ref_info.legacy == ($past(cache_rdata[63:48]) == 16'h0000))
    else $error("legacy flag does not follow upper word");
  chk_native_limit: assert property (
    pend_reg && cache_rdata[63:48] != 16'h0000 |=>
      ref_info.limit == {$past(cache_rdata[51:48]), $past(cache_rdata[15:0])})
    else $error("native limit wrong");
  chk_param_bytes: assert property (
    gate_valid && gate_desc[43] |=> gate_info.param_bytes == 7'($past(gate_desc[36:32])) * 7'd4)
    else $error("native parameter size wrong");
  chk_push_width: assert property (
    gate_valid |=> gate_info.push_wide == $past(stack_b_bit) && gate_done)
    else $error("push width mismatch");
  chk_gate_offset: assert property (
    gate_valid && !gate_desc[43] |=> gate_info.dest_offset[31:16] == 16'h0000)
    else $error("legacy gate offset too wide");
  chk_fetch_addr: assert property (
    seg_wr_valid && seg_wr_ready |=> mem_req && mem_addr ==
      ($past(seg_wr_selector[2]) ? $past(local_table_base) : $past(global_table_base)) +
      {16'h0000, $past(seg_wr_selector[15:3]), 3'b000})
    else $error("descriptor fetch address wrong");
  chk_two_words: assert property (
    state_reg == ST_FETCH_LO && mem_ack |=> state_reg == ST_FETCH_HI && mem_req)
    else $error("second descriptor word not fetched");
  chk_no_refetch: assert property (
    state_reg == ST_IDLE && !(seg_wr_valid && seg_wr_ready) |=> !mem_req)
    else $error("memory read without selector load");
  chk_cache_write: assert property (
    cache_we |=> seg_load_done && seg_wr_ready)
    else $error("cache written outside a reload");
  chk_absent_gate: assert property (
    gate_valid && !gate_desc[47] |=> gate_info.fault_vec == VEC_NOT_PRESENT)
    else $error("absent gate did not fault");
  chk_task_target: assert property (
    gate_valid && gate_desc[47] && gate_desc[43:40] == 4'h5 && target_desc[44]
      |=> gate_info.fault_vec == VEC_GEN_PROT)
    else $error("task gate to non-task target did not fault");

  cov_load: cover property (seg_wr_valid && seg_wr_ready ##[2:20] seg_load_done);
  cov_ref: cover property (ref_valid ##2 ref_done && !ref_info.legacy);
  cov_gate_ok: cover property (gate_valid ##1 gate_info.fault_vec == VEC_NONE);

endmodule // segment_descriptor_decode_cache

// File: tb/desc_table_mem.sv
/*
  Behavioural descriptor table memory answering the cache's 32-bit reads.
  Assumes the core clock and the design's level request, pulse ack handshake.
*/
`timescale 1ns/1ps
module desc_table_mem
(
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        mem_req,
  input  wire logic [31:0] mem_addr,
  input  wire logic [3:0]  wait_cycles,
  output logic             mem_ack,
  output logic      [31:0] mem_rdata
);
  logic [31:0] words [0:255];
  logic [3:0]  cnt;

  // ----------------------------------------------------------------
  // Table edits
  // ----------------------------------------------------------------
  // Edits land in memory only; cached copies stay stale until reload
  task automatic put(input logic [9:0] addr, input logic [63:0] desc);
    words[addr[9:2]]         = desc[31:0];
    words[addr[9:2] + 8'h01] = desc[63:32];
  endtask

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Data toggles off the ack so stale data is never read as valid
  always @(posedge core_clk)
  begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~mem_rdata;
    if (!rst_n)
    begin
      cnt       <= 4'h0;
      mem_rdata <= 32'h5A5A_A5A5;
    end
    else if (mem_req && !mem_ack)
    begin
      if (cnt >= wait_cycles)
      begin
        mem_ack   <= 1'b1;
        mem_rdata <= words[mem_addr[9:2]];
        cnt       <= 4'h0;
      end
      else
        cnt <= cnt + 4'h1;
    end
  end
endmodule // desc_table_mem

// File: tb/segment_descriptor_decode_cache_bench.sv
/*
  Self-checking bench for the descriptor decoder and cache.
  Assumes desc_table_mem as the table memory on the read port.
*/
`timescale 1ns/1ps
module segment_descriptor_decode_cache_bench;
  import seg_desc_pkg::*;

  localparam logic [63:0] D0 = 64'h89CF_DAAB_CDEF_1234;
  localparam logic [63:0] D1 = 64'h0000_F256_789A_BEEF;
  localparam logic [63:0] D2 = 64'h1140_9322_2222_0FFF;

  logic        core_clk;
  logic        rst_n;
  logic [31:0] global_table_base;
  logic [31:0] local_table_base;
  logic        seg_wr_valid;
  logic [2:0]  seg_wr_idx;
  logic [15:0] seg_wr_selector;
  logic        seg_wr_ready;
  logic        seg_load_done;
  sel_fields_s seg_sel_fields;
  logic        mem_req;
  logic [31:0] mem_addr;
  logic        mem_ack;
  logic [31:0] mem_rdata;
  logic        ref_valid;
  logic [2:0]  ref_idx;
  logic        ref_done;
  seg_info_s   ref_info;
  logic        gate_valid;
  logic [63:0] gate_desc;
  logic [63:0] target_desc;
  logic        stack_b_bit;
  logic        gate_done;
  gate_info_s  gate_info;
  logic [3:0]  mem_wait;
  int          miscompares;
  int          check_count;

  segment_descriptor_decode_cache i_dut (.core_clk(core_clk), .rst_n(rst_n),
    .global_table_base(global_table_base), .local_table_base(local_table_base),
    .seg_wr_valid(seg_wr_valid),
    .seg_wr_idx(seg_wr_idx), .seg_wr_selector(seg_wr_selector), .seg_wr_ready(seg_wr_ready),
    .seg_load_done(seg_load_done), .seg_sel_fields(seg_sel_fields), .mem_req(mem_req),
    .mem_addr(mem_addr), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .ref_valid(ref_valid),
    .ref_idx(ref_idx), .ref_done(ref_done), .ref_info(ref_info), .gate_valid(gate_valid),
    .gate_desc(gate_desc), .target_desc(target_desc), .stack_b_bit(stack_b_bit),
    .gate_done(gate_done), .gate_info(gate_info));

  desc_table_mem i_mem (.core_clk(core_clk), .rst_n(rst_n), .mem_req(mem_req),
    .mem_addr(mem_addr), .wait_cycles(mem_wait), .mem_ack(mem_ack), .mem_rdata(mem_rdata));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic print_verdict;
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic check(input logic [127:0] got, input logic [127:0] exp);
    check_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  // Ack count shows whether the whole 8-byte entry was fetched
  task automatic load_seg(input logic [2:0] slot, input logic [15:0] sel,
                          input logic [31:0] addr);
    int acks;
    int n;
    acks = 0;
    seg_wr_valid    = 1'b1;
    seg_wr_idx      = slot;
    seg_wr_selector = sel;
    tick;
    seg_wr_valid = 1'b0;
    check(128'(mem_addr), 128'(addr));
    check(128'(seg_sel_fields), 128'({sel[1:0], sel[2], sel[15:3]}));
    for (n = 0; n < 40 && seg_load_done !== 1'b1; n++)
    begin
      if (mem_ack === 1'b1)
        acks++;
      tick;
    end
    if (n == 40)
    begin
      miscompares++;
      print_verdict();
    end
    check(128'(acks), 128'(2));
  endtask

  task automatic do_ref(input logic [2:0] slot, input logic [63:0] d);
    seg_info_s e;
    e.legacy               = (d[63:48] == 16'h0000);
    e.base                 = {e.legacy ? 8'h00 : d[63:56], d[39:32], d[31:16]};
    e.limit                = {e.legacy ? 4'h0 : d[51:48], d[15:0]};
    e.gran                 = d[55] & ~e.legacy;
    e.big                  = d[54];
    e.present              = d[47];
    e.descriptor_privilege = d[46:45];
    e.code_data            = d[44];
    e.seg_type             = d[43:40];
    ref_valid = 1'b1;
    ref_idx   = slot;
    tick;
    ref_valid = 1'b0;
    check(128'(mem_req), 128'(0));
    tick;
    check(128'(ref_done), 128'(1));
    check(128'(ref_info), 128'(e));
  endtask

  task automatic gate_case(input logic [3:0] ty, input logic p, input logic ts,
                           input logic [3:0] tt, input logic b, input logic [4:0] wc);
    gate_info_s e;
    logic       nat;
    nat         = ty[3];
    gate_desc   = {nat ? 16'h1234 : 16'h0000, p, 3'h0, ty, 3'h0, wc, 16'h004B, 16'h5678};
    target_desc = {16'h0000, 1'b1, 2'h0, ts, tt, 40'h12_3456_789A};
    e.dest_selector = 16'h004B;
    e.dest_offset   = {nat ? 16'h1234 : 16'h0000, 16'h5678};
    e.word_count    = wc;
    e.param_bytes   = nat ? {wc, 2'h0} : {1'b0, wc, 1'b0};
    e.native        = nat;
    e.task_gate     = (ty == 4'h5);
    e.push_wide     = b;
    if (!p)
      e.fault_vec = 8'h0B;
    else if (e.task_gate ? (ts || !(tt inside {4'h1, 4'h3, 4'h9, 4'hB})) : (!ts || !tt[3]))
      e.fault_vec = 8'h0D;
    else
      e.fault_vec = 8'h00;
    gate_valid  = 1'b1;
    stack_b_bit = b;
    tick;
    gate_valid = 1'b0;
    check(128'(gate_done), 128'(1));
    check(128'(gate_info), 128'(e));
  endtask

  // ----------------------------------------------------------------
  // Clock and sequence
  // ----------------------------------------------------------------
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  initial
  begin
    {rst_n, seg_wr_valid, seg_wr_idx, seg_wr_selector, ref_valid, ref_idx} = '0;
    {gate_valid, gate_desc, target_desc, stack_b_bit, mem_wait} = '0;
    miscompares = 0;
    check_count = 0;
    global_table_base = 32'h0000_0100;
    local_table_base  = 32'h0000_0200;
    i_mem.put(10'h110, D0);
    i_mem.put(10'h228, D1);
    repeat (20) tick;
    check(128'({seg_wr_ready, seg_load_done, mem_req, ref_done, gate_done}), 128'(5'h10));
    rst_n = 1'b1;
    load_seg(3'h0, 16'h0013, 32'h0000_0110);
    mem_wait = 4'h3;
    load_seg(3'h5, 16'h002D, 32'h0000_0228);
    do_ref(3'h0, D0);
    do_ref(3'h5, D1);
    // Table edited behind the cache: old copy must still be served
    i_mem.put(10'h110, D2);
    do_ref(3'h0, D0);
    mem_wait = 4'h0;
    load_seg(3'h0, 16'h0013, 32'h0000_0110);
    do_ref(3'h0, D2);
    gate_case(4'h4, 1'h1, 1'h1, 4'hA, 1'h0, 5'h03);
    gate_case(4'hC, 1'h1, 1'h1, 4'hE, 1'h1, 5'h1F);
    gate_case(4'h5, 1'h1, 1'h0, 4'h9, 1'h0, 5'h00);
    gate_case(4'h5, 1'h1, 1'h0, 4'h3, 1'h1, 5'h00);
    gate_case(4'hE, 1'h1, 1'h1, 4'hA, 1'h1, 5'h00);
    gate_case(4'h7, 1'h1, 1'h1, 4'hA, 1'h0, 5'h02);
    gate_case(4'hF, 1'h0, 1'h1, 4'hA, 1'h1, 5'h01);
    gate_case(4'hC, 1'h1, 1'h1, 4'h2, 1'h1, 5'h04);
    gate_case(4'h5, 1'h1, 1'h1, 4'hA, 1'h0, 5'h00);
    gate_case(4'h6, 1'h1, 1'h0, 4'hB, 1'h0, 5'h01);
    print_verdict();
  end
endmodule // segment_descriptor_decode_cache_bench
